// File: hdl/slw_top.sv
// top: high-side switch, lin and window watchdog control
//
// Contract
// - outputs a,b need enable bit and pwm high
// - output c follows its enable bit only
// - overtemperature outside stop/sleep latches all switches off
// - sleep or stop forces all switches off
// - slew field selects rate, resets to 20k
// - lin transmitter only in normal, normal request
// - lin fault disables transmitter, sets failure flag
// - pullup disconnect bit uses current source lowpower
// - transmit low drives dominant, high recessive
// - undriven transmit pin reads recessive
// - receive pin mirrors bus level
// - stop/sleep: transmitter off, receiver watches bus
// - stop wake-up raises interrupt, sets wake flag
// - sleep wake-up resets device, sets wake flag
// - closed-window or missing clear resets device
// - first clear has no closed window
// - open pin default period, grounded disables
// - resistor period 0.991 r plus 0.648 ms
// - regulator warning sets flag, raises interrupt (masked in stop/sleep)
// - slew codes 20k,10k,100k,lowpower request
// - mode codes sleep,stop,clear,run
// - lin re-enable after fault gone, flag read
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module slw_top
    import slw_pkg::*;
#(
    parameter int WD_FIRST_CYC = WD_FIRST_MS * CYC_PER_MS,
    parameter int WD_DEFAULT_CYC = WD_DEFAULT_MS * CYC_PER_MS,
    parameter int CYC_PER_US = CLK_MHZ,
    parameter int WAKE_CYC = WAKE_FILTER_CYC
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic [1:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    input wire logic PWM_GATE_I,
    input wire logic HS_OVERTEMP_I,
    input wire logic LIN_TX_I,
    input wire logic LIN_TX_DRIVEN_I,
    input wire logic LIN_BUS_I,
    input wire logic LIN_FAULT_I,
    input wire logic REG_TEMP_WARN_I,
    input wire logic [1:0] WDCFG_I,
    output logic HIGH_SIDE_OUT_A_O,
    output logic HIGH_SIDE_OUT_B_O,
    output logic HIGH_SIDE_OUT_C_O,
    output logic LIN_TX_EN_O,
    output logic LIN_DOMINANT_O,
    output logic LIN_RX_O,
    output logic [1:0] LIN_SLEW_O,
    output logic LIN_PULLUP_ON_O,
    output logic LIN_CURSRC_ON_O,
    output logic IRQ_O,
    output logic RESET_REQ_O,
    output logic [1:0] MODE_O
);
    typedef enum logic [2:0] {
        M_RESET, M_NREQ, M_RUN, M_STOP, M_SLEEP
    } slw_mode_t;

    typedef struct packed {
        slw_mode_t mode;
        logic [7:0] ctl;
        logic pend_lp;
        logic [1:0] pend_code;
        logic switch_thermal_shutdown_flag;
        logic lin_fail;
        logic lin_wake;
        logic regulator_temp_warning_flag;
        logic irq;
        logic rst_req;
        logic [CNT_W-1:0] wd_cnt;
        logic [CNT_W-1:0] wd_period;
        logic [15:0] wd_res;
        logic [15:0] rdata;
        logic [1:0] hs_out_ab;
        logic hs_out_c;
        logic tx_en;
        logic dom;
        logic rx;
    } slw_state_t;

    slw_state_t s_q, s_d;
    logic wake_pulse;

    function automatic logic is_lowpower(input slw_mode_t m);
        return (m == M_STOP) || (m == M_SLEEP);
    endfunction

    //////////////////////////////////////////////////////////////////////
    // wake-up qualifier
    slw_wakeup_filter #(
        .FILTER_CYC(WAKE_CYC)
    ) u_wake (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .arm_i(is_lowpower(s_q.mode)),
        .bus_rx_i(LIN_BUS_I),
        .wake_o(wake_pulse)
    );

    //////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic wr_ctl;
        logic rd_st;
        logic [1:0] mcode;
        logic [CNT_W-1:0] half;
        logic tx_lvl;
        logic [CNT_W-1:0] res_cyc;
        wr_ctl = WR_I && (ADDR_I == ADDR_CTL);
        rd_st = RD_I && (ADDR_I == ADDR_STAT);
        mcode = WDATA_I[CTL_MODE_HI:CTL_MODE_LO];
        half = s_q.wd_period >> 1;
        tx_lvl = LIN_TX_DRIVEN_I ? LIN_TX_I : 1'b1;
        res_cyc = CNT_W'((WD_GAIN_US * s_q.wd_res + WD_OFS_US)
            * CYC_PER_US);
        s_d = s_q;
        s_d.irq = 1'b0;
        s_d.rst_req = 1'b0;
        s_d.rdata = '0;
        if (s_q.mode == M_RESET) begin
            s_d.mode = M_NREQ;
            s_d.wd_cnt = '0;
            s_d.wd_period = CNT_W'(WD_FIRST_CYC);
        end else begin
            if (s_q.wd_cnt != '1) begin
                s_d.wd_cnt = s_q.wd_cnt + 1'b1;
            end
        end
        // register writes
        if (WR_I && (ADDR_I == ADDR_WDRES)) begin
            s_d.wd_res = WDATA_I;
        end
        if (wr_ctl) begin
            s_d.ctl = WDATA_I[7:0];
            // low-power entry needs the same command twice
            if ((WDATA_I[CTL_SLEW_HI:CTL_SLEW_LO] == SLEW_LOWPWR)
                && (mcode == MODE_SLEEP || mcode == MODE_STOP)) begin
                if (s_q.pend_lp && s_q.pend_code == mcode) begin
                    s_d.mode = (mcode == MODE_SLEEP) ? M_SLEEP
                        : M_STOP;
                    s_d.pend_lp = 1'b0;
                end else begin
                    s_d.pend_lp = 1'b1;
                    s_d.pend_code = mcode;
                end
            end else begin
                s_d.pend_lp = 1'b0;
                if (mcode == MODE_WDCLR && WDCFG_I != WDCFG_GND) begin
                    if (s_q.mode == M_RUN && s_q.wd_cnt < half) begin
                        s_d.rst_req = 1'b1;
                    end
                    s_d.wd_cnt = '0;
                    s_d.wd_period = (WDCFG_I == WDCFG_RES) ? res_cyc
                        : CNT_W'(WD_DEFAULT_CYC);
                    if (s_q.mode == M_NREQ) begin
                        s_d.mode = M_RUN;
                    end
                end else if (mcode == MODE_RUN && s_q.mode == M_NREQ
                    && WDCFG_I == WDCFG_GND) begin
                    s_d.mode = M_RUN;
                end
            end
        end
        // watchdog expiry
        if ((s_q.mode == M_NREQ || s_q.mode == M_RUN)
            && WDCFG_I != WDCFG_GND && s_q.wd_cnt >= s_q.wd_period) begin
            s_d.rst_req = 1'b1;
        end
        // switch thermal latch, not cleared by reads, only by device reset
        if (HS_OVERTEMP_I && !is_lowpower(s_q.mode)) begin
            s_d.switch_thermal_shutdown_flag = 1'b1;
            s_d.irq = !s_q.switch_thermal_shutdown_flag;
        end
        // lin fault flag: cleared by read while set, set wins
        if (rd_st && s_q.lin_fail && !LIN_FAULT_I) begin
            s_d.lin_fail = 1'b0;
        end
        if (LIN_FAULT_I) begin
            s_d.lin_fail = 1'b1;
        end
        if (rd_st && s_q.lin_wake) begin
            s_d.lin_wake = 1'b0;
        end
        if (wake_pulse) begin
            s_d.lin_wake = 1'b1;
            if (s_q.mode == M_STOP) begin
                s_d.irq = 1'b1;
                s_d.mode = M_RUN;
                s_d.wd_cnt = '0;
            end else begin
                s_d.rst_req = 1'b1;
            end
        end
        // regulator warning follows the condition
        s_d.regulator_temp_warning_flag = REG_TEMP_WARN_I && !is_lowpower(s_q.mode);
        if (REG_TEMP_WARN_I && !s_q.regulator_temp_warning_flag && !is_lowpower(s_q.mode)) begin
            s_d.irq = 1'b1;
        end
        if (rd_st) begin
            s_d.rdata = 16'(8'(s_q.irq) << ST_INT_BIT);
            s_d.rdata[ST_LIN_BIT] = s_q.lin_fail || s_q.lin_wake;
            s_d.rdata[ST_REGULATOR_TEMP_WARNING_FLAG_BIT] = s_q.regulator_temp_warning_flag;
            s_d.rdata[ST_SWITCH_THERMAL_SHUTDOWN_FLAG_BIT] = s_q.switch_thermal_shutdown_flag;
        end else if (RD_I && ADDR_I == ADDR_CTL) begin
            s_d.rdata = {8'h00, s_q.ctl};
        end else if (RD_I && ADDR_I == ADDR_WDRES) begin
            s_d.rdata = s_q.wd_res;
        end
        // outputs
        s_d.hs_out_ab[0] = s_d.ctl[CTL_HSA_BIT] && PWM_GATE_I;
        s_d.hs_out_ab[1] = s_d.ctl[CTL_HSB_BIT] && PWM_GATE_I;
        s_d.hs_out_c = s_d.ctl[CTL_HSC_BIT];
        if (s_d.switch_thermal_shutdown_flag || is_lowpower(s_d.mode)
            || s_d.mode == M_RESET) begin
            s_d.hs_out_ab = 2'b00;
            s_d.hs_out_c = 1'b0;
        end
        s_d.tx_en = (s_d.mode == M_NREQ || s_d.mode == M_RUN)
            && !s_d.lin_fail;
        s_d.dom = s_d.tx_en && !tx_lvl;
        s_d.rx = LIN_BUS_I;
        // whole-device reset from the watchdog or sleep wake
        if (s_d.rst_req) begin
            s_d.mode = M_RESET;
            s_d.ctl = CTL_RESET;
            s_d.switch_thermal_shutdown_flag = 1'b0;
            s_d.pend_lp = 1'b0;
            s_d.hs_out_ab = 2'b00;
            s_d.hs_out_c = 1'b0;
            s_d.tx_en = 1'b0;
            s_d.dom = 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s_q <= '{mode: M_RESET, ctl: CTL_RESET, rx: 1'b1,
                default: '0};
        end else if (CE_I) begin
            s_q <= s_d;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // outputs
    assign RDATA_O = s_q.rdata;
    assign HIGH_SIDE_OUT_A_O = s_q.hs_out_ab[0];
    assign HIGH_SIDE_OUT_B_O = s_q.hs_out_ab[1];
    assign HIGH_SIDE_OUT_C_O = s_q.hs_out_c;
    assign LIN_TX_EN_O = s_q.tx_en;
    assign LIN_DOMINANT_O = s_q.dom;
    assign LIN_RX_O = s_q.rx;
    assign LIN_SLEW_O = s_q.ctl[CTL_SLEW_HI:CTL_SLEW_LO];
    assign LIN_PULLUP_ON_O = !(s_q.ctl[CTL_PU_BIT]
        && is_lowpower(s_q.mode));
    assign LIN_CURSRC_ON_O = !LIN_PULLUP_ON_O;
    assign IRQ_O = s_q.irq;
    assign RESET_REQ_O = s_q.rst_req;
    assign MODE_O = (s_q.mode == M_RUN) ? MODE_RUN
        : (s_q.mode == M_STOP) ? MODE_STOP
        : (s_q.mode == M_SLEEP) ? MODE_SLEEP : MODE_WDCLR;

    //////////////////////////////////////////////////////////////////////
    // checks
    property p_hs_gate;
        @(posedge CLK_I) disable iff (!RST_N_I)
        $past(CE_I) && HIGH_SIDE_OUT_A_O |-> $past(PWM_GATE_I);
    endproperty
    a_hs_gate: assert property (p_hs_gate) else $error("a on no pwm");
    property p_hs_c;
        @(posedge CLK_I) disable iff (!RST_N_I)
        HIGH_SIDE_OUT_C_O |-> s_q.ctl[CTL_HSC_BIT];
    endproperty
    a_hs_c: assert property (p_hs_c) else $error("c on unset");
    property p_switch_thermal_shutdown_flag;
        @(posedge CLK_I) disable iff (!RST_N_I)
        s_q.switch_thermal_shutdown_flag |-> !HIGH_SIDE_OUT_A_O && !HIGH_SIDE_OUT_B_O
            && !HIGH_SIDE_OUT_C_O;
    endproperty
    a_switch_thermal_shutdown_flag: assert property (p_switch_thermal_shutdown_flag) else $error("hs on latch");
    property p_lp_hs;
        @(posedge CLK_I) disable iff (!RST_N_I)
        is_lowpower(s_q.mode) |-> !HIGH_SIDE_OUT_A_O && !HIGH_SIDE_OUT_B_O
            && !HIGH_SIDE_OUT_C_O;
    endproperty
    a_lp_hs: assert property (p_lp_hs) else $error("hs lowpower");
    property p_tx_mode;
        @(posedge CLK_I) disable iff (!RST_N_I)
        LIN_TX_EN_O |-> (s_q.mode == M_NREQ || s_q.mode == M_RUN);
    endproperty
    a_tx_mode: assert property (p_tx_mode) else $error("tx mode");
    property p_fail;
        @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
        LIN_FAULT_I ##1 CE_I |-> s_q.lin_fail && !LIN_TX_EN_O;
    endproperty
    a_fail: assert property (p_fail) else $error("fault tx");
    property p_dom;
        @(posedge CLK_I) disable iff (!RST_N_I)
        LIN_DOMINANT_O |-> LIN_TX_EN_O;
    endproperty
    a_dom: assert property (p_dom) else $error("dom tx off");
    property p_wake;
        @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
        wake_pulse && s_q.mode == M_STOP |=> IRQ_O;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake irq");
    property p_slp_wake;
        @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
        wake_pulse && s_q.mode == M_SLEEP |=> RESET_REQ_O;
    endproperty
    a_slp_wake: assert property (p_slp_wake) else $error("slp wake");
    property p_rx;
        @(posedge CLK_I) disable iff (!RST_N_I)
        $past(CE_I) && $past(RST_N_I) |-> LIN_RX_O == $past(LIN_BUS_I);
    endproperty
    a_rx: assert property (p_rx) else $error("rx not bus");
    property p_tx_idle;
        @(posedge CLK_I) disable iff (!RST_N_I)
        LIN_DOMINANT_O && $past(CE_I) && $past(RST_N_I)
            |-> $past(LIN_TX_DRIVEN_I) && !$past(LIN_TX_I);
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("tx idle dom");
    // clear code written in the first half of a run period
    sequence s_closed_clear;
        CE_I && WR_I && ADDR_I == ADDR_CTL && WDCFG_I != WDCFG_GND
            && WDATA_I[CTL_MODE_HI:CTL_MODE_LO] == MODE_WDCLR
            && s_q.mode == M_RUN && s_q.wd_cnt < (s_q.wd_period >> 1);
    endsequence
    property p_closed;
        @(posedge CLK_I) disable iff (!RST_N_I)
        s_closed_clear |=> RESET_REQ_O;
    endproperty
    a_closed: assert property (p_closed) else $error("early clear");
endmodule
`default_nettype wire

// File: hdl/slw_pkg.sv
// package: constants for the switch, lin and watchdog control block
package slw_pkg;
    // control byte fields
    localparam int CTL_SLEW_HI = 7;
    localparam int CTL_SLEW_LO = 6;
    localparam int CTL_PU_BIT = 5;
    localparam int CTL_HSC_BIT = 4;
    localparam int CTL_HSB_BIT = 3;
    localparam int CTL_HSA_BIT = 2;
    localparam int CTL_MODE_HI = 1;
    localparam int CTL_MODE_LO = 0;
    localparam logic [7:0] CTL_RESET = 8'h03;
    // status byte fields
    localparam int ST_INT_BIT = 7;
    localparam int ST_LIN_BIT = 6;
    localparam int ST_REGULATOR_TEMP_WARNING_FLAG_BIT = 3;
    localparam int ST_SWITCH_THERMAL_SHUTDOWN_FLAG_BIT = 2;
    // mode select field codes
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_STOP = 2'h1;
    localparam logic [1:0] MODE_WDCLR = 2'h2;
    localparam logic [1:0] MODE_RUN = 2'h3;
    // slew select codes
    localparam logic [1:0] SLEW_20K = 2'h0;
    localparam logic [1:0] SLEW_10K = 2'h1;
    localparam logic [1:0] SLEW_100K = 2'h2;
    localparam logic [1:0] SLEW_LOWPWR = 2'h3;
    // register port addresses
    localparam logic [1:0] ADDR_CTL = 2'h0;
    localparam logic [1:0] ADDR_STAT = 2'h1;
    localparam logic [1:0] ADDR_WDRES = 2'h2;
    // timing
    localparam int CLK_MHZ = 125;
    localparam int WD_DEFAULT_MS = 150;
    localparam int WD_FIRST_MS = 150;
    localparam int WAKE_FILTER_US = 30;
    localparam int WAKE_FILTER_CYC = (WAKE_FILTER_US * CLK_MHZ);
    localparam int CYC_PER_MS = 1000 * CLK_MHZ;
    // period in us = 991 * r_kohm / 1000 * 1000 ... in us: 991*r + 648
    localparam int WD_GAIN_US = 991;
    localparam int WD_OFS_US = 648;
    // watchdog pin configuration codes
    localparam logic [1:0] WDCFG_OPEN = 2'h0;
    localparam logic [1:0] WDCFG_GND = 2'h1;
    localparam logic [1:0] WDCFG_RES = 2'h2;
    localparam int CNT_W = 32;
endpackage

// File: hdl/slw_wakeup_filter.sv
// lin bus wake-up qualifier: long dominant then rising edge
`timescale 1ns/1ps
`default_nettype none
module slw_wakeup_filter
    import slw_pkg::*;
#(
    parameter int FILTER_CYC = WAKE_FILTER_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic arm_i,
    input wire logic bus_rx_i,
    output logic wake_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic long_dom;
        logic wake;
    } slw_wf_state_t;
    slw_wf_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.wake = 1'b0;
        if (!arm_i) begin
            s_d.cnt = '0;
            s_d.long_dom = 1'b0;
        end else if (!bus_rx_i) begin
            if (s_q.cnt >= CNT_W'(FILTER_CYC)) begin
                s_d.long_dom = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end else begin
            s_d.wake = s_q.long_dom;
            s_d.cnt = '0;
            s_d.long_dom = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end
    assign wake_o = s_q.wake;
endmodule
`default_nettype wire

// File: bench/slw_lin_partner.sv
// partner model: controller transmit pin and lin bus wire
`timescale 1ns/1ps
`default_nettype none
module slw_lin_partner (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tx_bit_i,
    input wire logic tx_drive_i,
    input wire logic dev_dom_i,
    input wire logic ext_dom_i,
    output logic tx_pin_o,
    output logic tx_driven_o,
    output logic bus_o
);
    logic last_q;
    ////////////////////////////////////////////////////////////////////////
    // released pin shows the inverse of the last driven level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_q <= 1'b1;
        end else if (tx_drive_i) begin
            last_q <= tx_bit_i;
        end
    end
    assign tx_driven_o = tx_drive_i;
    assign tx_pin_o = tx_drive_i ? tx_bit_i : ~last_q;
    ////////////////////////////////////////////////////////////////////////
    // pull-up: recessive unless some node drives dominant
    assign bus_o = ~(dev_dom_i | ext_dom_i);
endmodule
`default_nettype wire

// File: bench/tb_slw_top.sv
// testbench: register port sequences for the switch lin watchdog block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_slw_top;
    import slw_pkg::*;
    logic CLK_I = 0, RST_N_I = 0, WR_I = 0, RD_I = 0, PWM_GATE_I = 0;
    logic HS_OVERTEMP_I = 0, LIN_FAULT_I = 0, REG_TEMP_WARN_I = 0;
    logic [1:0] ADDR_I = 0, WDCFG_I = WDCFG_GND;
    logic [15:0] WDATA_I = 0, RDATA_O, d;
    logic LIN_TX_I, LIN_TX_DRIVEN_I, LIN_BUS_I, HIGH_SIDE_OUT_A_O;
    logic HIGH_SIDE_OUT_B_O, HIGH_SIDE_OUT_C_O, LIN_TX_EN_O, LIN_DOMINANT_O;
    logic LIN_RX_O, LIN_PULLUP_ON_O, LIN_CURSRC_ON_O, IRQ_O, RESET_REQ_O;
    logic [1:0] LIN_SLEW_O, MODE_O;
    logic tx_bit = 1, tx_drive = 1, ext_dom = 0;
    logic CE_I = 1;
    int error_cnt = 0, compares = 0, n;
    always #4 CLK_I = ~CLK_I;
    slw_top #(.WD_FIRST_CYC(200), .WD_DEFAULT_CYC(100), .CYC_PER_US(1),
        .WAKE_CYC(10)) u_slw_top (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
        .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
        .RD_I(RD_I), .RDATA_O(RDATA_O), .PWM_GATE_I(PWM_GATE_I),
        .HS_OVERTEMP_I(HS_OVERTEMP_I), .LIN_TX_I(LIN_TX_I),
        .LIN_TX_DRIVEN_I(LIN_TX_DRIVEN_I), .LIN_BUS_I(LIN_BUS_I),
        .LIN_FAULT_I(LIN_FAULT_I), .REG_TEMP_WARN_I(REG_TEMP_WARN_I),
        .WDCFG_I(WDCFG_I), .HIGH_SIDE_OUT_A_O(HIGH_SIDE_OUT_A_O),
        .HIGH_SIDE_OUT_B_O(HIGH_SIDE_OUT_B_O),
        .HIGH_SIDE_OUT_C_O(HIGH_SIDE_OUT_C_O), .LIN_TX_EN_O(LIN_TX_EN_O),
        .LIN_DOMINANT_O(LIN_DOMINANT_O), .LIN_RX_O(LIN_RX_O),
        .LIN_SLEW_O(LIN_SLEW_O), .LIN_PULLUP_ON_O(LIN_PULLUP_ON_O),
        .LIN_CURSRC_ON_O(LIN_CURSRC_ON_O), .IRQ_O(IRQ_O),
        .RESET_REQ_O(RESET_REQ_O), .MODE_O(MODE_O));
    slw_lin_partner u_slw_lin_partner (.clk_i(CLK_I), .rst_n_i(RST_N_I),
        .tx_bit_i(tx_bit), .tx_drive_i(tx_drive), .dev_dom_i(LIN_DOMINANT_O),
        .ext_dom_i(ext_dom), .tx_pin_o(LIN_TX_I),
        .tx_driven_o(LIN_TX_DRIVEN_I), .bus_o(LIN_BUS_I));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge CLK_I);
        #1;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= {8'h00, v};
        WR_I <= 1'b1;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge CLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1;
        d = RDATA_O;
    endtask
    task automatic wait_evt(input bit rst, input int mx, output int c);
        c = 0;
        #1;
        while (c < mx && (rst ? RESET_REQ_O : IRQ_O) !== 1'b1) begin
            @(posedge CLK_I);
            #1;
            c++;
        end
    endtask
    task automatic do_reset();
        @(posedge CLK_I);
        RST_N_I <= 1'b0;
        repeat (6) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        wt(2);
    endtask
    task automatic wake(input bit rst);
        @(posedge CLK_I);
        ext_dom <= 1'b1;
        wt(20);
        `CHK("rx dominant", 1'b0, LIN_RX_O)
        ext_dom <= 1'b0;
        wait_evt(rst, 12, n);
    endtask
    initial begin
        #(8 * 60000);
        error_cnt++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        `CHK("slew", SLEW_20K, LIN_SLEW_O)
        `CHK("mode", MODE_WDCLR, MODE_O)
        `CHK("tx en", 1'b1, LIN_TX_EN_O)
        `CHK("pullup", 1'b1, LIN_PULLUP_ON_O)
        rd(2'h3);
        `CHK("unmapped", 16'h0000, d)
        for (int i = 0; i < 16; i++) begin
            @(posedge CLK_I);
            PWM_GATE_I <= i[3];
            wr(ADDR_CTL, {3'b000, i[2:0], MODE_RUN});
            wt(3);
            `CHK("hs a", i[0] & i[3], HIGH_SIDE_OUT_A_O)
            `CHK("hs b", i[1] & i[3], HIGH_SIDE_OUT_B_O)
            `CHK("hs c", i[2], HIGH_SIDE_OUT_C_O)
        end
        `CHK("mode run", MODE_RUN, MODE_O)
        CE_I <= 1'b0;
        wr(ADDR_CTL, 8'h03);
        CE_I <= 1'b1;
        wt(2);
        `CHK("ce hold", 1'b1, HIGH_SIDE_OUT_C_O)
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_CTL, {k[1:0], 6'h03});
            wt(3);
            `CHK("slew sel", k[1:0], LIN_SLEW_O)
        end
        rd(ADDR_CTL);
        `CHK("ctl read", {8'h00, SLEW_100K, 6'h03}, d)
        for (int k = 0; k < 2; k++) begin
            @(posedge CLK_I);
            tx_bit <= k[0];
            wt(4);
            `CHK("dominant", ~k[0], LIN_DOMINANT_O)
            `CHK("rx", k[0], LIN_RX_O)
        end
        @(posedge CLK_I);
        tx_drive <= 1'b0;
        wt(4);
        `CHK("undriven tx", 1'b0, LIN_DOMINANT_O)
        tx_drive <= 1'b1;
        LIN_FAULT_I <= 1'b1;
        wt(3);
        `CHK("fault tx en", 1'b0, LIN_TX_EN_O)
        rd(ADDR_STAT);
        `CHK("fail flag", 1'b1, d[ST_LIN_BIT])
        LIN_FAULT_I <= 1'b0;
        wt(3);
        `CHK("tx en held", 1'b0, LIN_TX_EN_O)
        rd(ADDR_STAT);
        wt(3);
        `CHK("tx en back", 1'b1, LIN_TX_EN_O)
        rd(ADDR_STAT);
        `CHK("fail clear", 1'b0, d[ST_LIN_BIT])
        @(posedge CLK_I);
        REG_TEMP_WARN_I <= 1'b1;
        wait_evt(0, 10, n);
        `CHK("warn irq", 1'b1, n < 10)
        rd(ADDR_STAT);
        `CHK("warn flag", 1'b1, d[ST_REGULATOR_TEMP_WARNING_FLAG_BIT])
        REG_TEMP_WARN_I <= 1'b0;
        PWM_GATE_I <= 1'b1;
        wr(ADDR_CTL, 8'h1f);
        HS_OVERTEMP_I <= 1'b1;
        wt(2);
        HS_OVERTEMP_I <= 1'b0;
        wt(4);
        rd(ADDR_STAT);
        `CHK("switch_thermal_shutdown_flag flag", 1'b1, d[ST_SWITCH_THERMAL_SHUTDOWN_FLAG_BIT])
        `CHK("hs latched", 3'b000, {HIGH_SIDE_OUT_A_O, HIGH_SIDE_OUT_B_O,
            HIGH_SIDE_OUT_C_O})
        for (int s = 0; s < 2; s++) begin
            do_reset();
            wr(ADDR_CTL, 8'h1f);
            wr(ADDR_CTL, {7'h70, ~s[0]});
            wr(ADDR_CTL, {7'h70, ~s[0]});
            wt(3);
            `CHK("low mode", {1'b0, ~s[0]}, MODE_O)
            `CHK("lp tx en", 1'b0, LIN_TX_EN_O)
            `CHK("lp hs a", 1'b0, HIGH_SIDE_OUT_A_O)
            `CHK("lp hs c", 1'b0, HIGH_SIDE_OUT_C_O)
            `CHK("pu off", 1'b0, LIN_PULLUP_ON_O)
            `CHK("cursrc", 1'b1, LIN_CURSRC_ON_O)
            wake(s[0]);
            `CHK("wake event", 1'b1, n < 12)
            rd(ADDR_STAT);
            `CHK("wake flag", 1'b1, d[ST_LIN_BIT])
        end
        WDCFG_I <= WDCFG_OPEN;
        do_reset();
        wait_evt(1, 260, n);
        `CHK("first timeout", 1'b1, n >= 185 && n <= 205)
        wt(5);
        wr(ADDR_CTL, {6'h00, MODE_WDCLR});
        wt(20);
        wr(ADDR_CTL, {6'h00, MODE_WDCLR});
        wait_evt(1, 6, n);
        `CHK("closed clear", 1'b1, n < 6)
        wr(ADDR_CTL, {6'h00, MODE_WDCLR});
        wt(70);
        wr(ADDR_CTL, {6'h00, MODE_WDCLR});
        wait_evt(1, 40, n);
        `CHK("open clear", 40, n)
        wait_evt(1, 120, n);
        `CHK("no clear", 1'b1, n < 120)
        WDCFG_I <= WDCFG_RES;
        do_reset();
        wr(ADDR_WDRES, 8'h01);
        rd(ADDR_WDRES);
        `CHK("wd res", 16'h0001, d)
        wr(ADDR_CTL, {6'h00, MODE_WDCLR});
        wait_evt(1, 1800, n);
        `CHK("res period", 1'b1, n >= 1630 && n <= 1650)
        WDCFG_I <= WDCFG_GND;
        do_reset();
        wait_evt(1, 400, n);
        `CHK("wd off", 400, n)
        close_out();
    end
endmodule
`default_nettype wire
